// ### rtl/amc_top.sv
// converter front-end control: input routing, amplifier and filter settings, serial port
//
// How it works
// - route positive and negative selects to amplifier
// - common input is an ordinary select code
// - channel change: mid-supply two clock periods first
// - monitor choice shorts inputs at mid-supply
// - monitor choices for supplies and temperature
// - burn-out sources pull selected inputs when enabled
// - sixteen-bit results, rate 2.5 to 4000
// - sinc3 mode line rejection by rate
// - low-latency mode settled data with rejection
// - clock from internal oscillator or pin
// - one four-signal serial port for everything
// - output line shows ready and carries data
// - optional check code appended to data
// - works with chip select held low
// - start by pin or by command
// - continuous or single-shot conversion mode
// - binary gains 1 to 128, or bypass
// - gpio shares inputs on twelve-input variant
// - amplifier enable 00 bypass, 01 enabled
// - gains 64 and 128 use 32 plus scaling
`timescale 1ns/1ps
`include "amc_consts.svh"
module amc_top
    import amc_pkg::*;
#(
    parameter int INPUT_COUNT = 12
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic start_sync,
    output logic combined_out_ready_line,
    output logic combined_out_ready_oe,
    input wire logic [15:0] conv_result,
    input wire logic conv_result_valid,
    output logic conv_result_ready,
    output logic conv_run,
    output logic [3:0] positive_input_select,
    output logic [3:0] negative_input_select,
    output logic inputs_connected,
    output logic inputs_mid_short,
    output logic [2:0] monitor_select,
    output logic burnout_enable,
    output logic amplifier_power_enable,
    output logic [2:0] pga_analog_gain,
    output logic [1:0] digital_gain_shift,
    output logic filter_low_latency,
    output logic [3:0] data_rate_code,
    output logic single_shot_mode,
    output logic clk_source_external,
    output logic gpio_on_analog_inputs
);
    localparam logic [5:0] BBM_CYCLES = 6'(`AMC_BBM_CYC);

    // pin synchronisers: cs_n, sclk, din, start_sync
    logic [3:0] pin_meta_r;
    logic [3:0] pin_sync_r;
    logic sclk_prev_r;
    logic start_prev_r;
    logic cs_s;
    logic sclk_s;
    logic din_s;
    logic start_s;
    logic sclk_fall;
    logic sclk_rise;
    logic start_edge;

    // serial byte receiver
    logic [2:0] bit_cnt_r;
    logic [6:0] rx_sh_r;
    logic byte_done;
    logic [7:0] rx_byte;

    // command sequencer
    amc_ser_state_type state_r;
    amc_ser_state_type state_nxt;
    logic [4:0] addr_r;
    logic [4:0] addr_nxt;
    logic [7:0] count_r;
    logic [7:0] count_nxt;
    logic is_write_r;
    logic is_write_nxt;
    logic wr_en;
    logic tx_load;
    logic [23:0] tx_load_val;
    logic pop;
    logic start_cmd;
    logic stop_cmd;

    // transmitter
    logic [23:0] tx_sh_r;
    logic tx_active_r;
    logic line_r;

    // configuration registers
    logic [7:0] chan_r;
    logic [7:0] gain_r;
    logic [7:0] rate_r;
    logic [7:0] sys_r;
    logic [7:0] applied_chan_r;
    logic [5:0] bbm_cnt_r;
    logic chan_change;

    // results
    amc_result_type fifo_out;
    logic fifo_valid;
    amc_result_type last_r;
    amc_result_type send_word;
    logic conv_run_r;
    logic [2:0] gain_code;
    logic pga_on;

    function automatic logic [7:0] amc_crc8(input logic [15:0] d);
        logic [7:0] c;
        c = `AMC_CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            if (c[7] ^ d[i]) begin
                c = {c[6:0], 1'b0} ^ `AMC_CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction : amc_crc8

    // two flip-flops on every pin before use
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_meta_r <= 4'h1;
            pin_sync_r <= 4'h1;
            sclk_prev_r <= 1'b0;
            start_prev_r <= 1'b0;
        end else begin
            pin_meta_r <= {start_sync, din, sclk, cs_n};
            pin_sync_r <= pin_meta_r;
            sclk_prev_r <= pin_sync_r[1];
            start_prev_r <= pin_sync_r[3];
        end
    end

    assign cs_s = pin_sync_r[0];
    assign sclk_s = pin_sync_r[1];
    assign din_s = pin_sync_r[2];
    assign start_s = pin_sync_r[3];
    assign sclk_fall = !cs_s && sclk_prev_r && !sclk_s;
    assign sclk_rise = !cs_s && !sclk_prev_r && sclk_s;
    assign start_edge = start_s && !start_prev_r;

    // bits are taken on the falling serial clock edge; framing is by byte count, and chip select high restarts it
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bit_cnt_r <= 3'h0;
            rx_sh_r <= 7'h00;
        end else if (cs_s) begin
            bit_cnt_r <= 3'h0;
        end else if (sclk_fall) begin
            rx_sh_r <= {rx_sh_r[5:0], din_s};
            bit_cnt_r <= bit_cnt_r + 3'h1;
        end
    end

    assign byte_done = sclk_fall && (bit_cnt_r == 3'h7);
    assign rx_byte = {rx_sh_r, din_s};

    // read-back of the register map
    function automatic logic [7:0] reg_value(input logic [4:0] a, input logic [7:0] status);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            `AMC_REG_STATUS: v = status;
            `AMC_REG_CHAN: v = chan_r;
            `AMC_REG_GAIN: v = gain_r;
            `AMC_REG_RATE: v = rate_r;
            `AMC_REG_SYS: v = sys_r;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : reg_value

    logic [7:0] status_val;
    assign status_val = {5'h00, conv_run_r, fifo_valid, (bbm_cnt_r != 6'h00)};
    assign send_word = fifo_valid ? fifo_out : last_r;

    // command decoder over one serial port for set-up and data
    always_comb begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        count_nxt = count_r;
        is_write_nxt = is_write_r;
        wr_en = 1'b0;
        tx_load = 1'b0;
        tx_load_val = 24'h000000;
        pop = 1'b0;
        start_cmd = 1'b0;
        stop_cmd = 1'b0;
        if (cs_s) begin
            state_nxt = SER_CMD;
        end else if (byte_done) begin
            unique case (state_r)
                SER_CMD: begin
                    if (rx_byte == `AMC_CMD_START) begin
                        start_cmd = 1'b1;
                    end else if (rx_byte == `AMC_CMD_STOP) begin
                        stop_cmd = 1'b1;
                    end else if (rx_byte == `AMC_CMD_RDATA) begin
                        tx_load = 1'b1;
                        tx_load_val = {send_word, amc_crc8(send_word)};
                        pop = fifo_valid;
                        count_nxt = sys_r[`AMC_SYS_CRC_BIT] ? 8'h02 : 8'h01;
                        state_nxt = SER_DATA;
                    end else if (rx_byte[7:5] == `AMC_CMD_RREG || rx_byte[7:5] == `AMC_CMD_WREG) begin
                        addr_nxt = rx_byte[4:0];
                        is_write_nxt = (rx_byte[7:5] == `AMC_CMD_WREG);
                        state_nxt = SER_COUNT;
                    end
                end
                SER_COUNT: begin
                    count_nxt = rx_byte;
                    if (is_write_r) begin
                        state_nxt = SER_WRITE;
                    end else begin
                        tx_load = 1'b1;
                        tx_load_val = {reg_value(addr_r, status_val), 16'h0000};
                        state_nxt = SER_READ;
                    end
                end
                SER_WRITE: begin
                    wr_en = 1'b1;
                    addr_nxt = addr_r + 5'h01;
                    count_nxt = count_r - 8'h01;
                    if (count_r == 8'h00) begin
                        state_nxt = SER_CMD;
                    end
                end
                SER_READ: begin
                    addr_nxt = addr_r + 5'h01;
                    count_nxt = count_r - 8'h01;
                    if (count_r == 8'h00) begin
                        state_nxt = SER_CMD;
                    end else begin
                        tx_load = 1'b1;
                        tx_load_val = {reg_value(addr_nxt, status_val), 16'h0000};
                    end
                end
                SER_DATA: begin
                    count_nxt = count_r - 8'h01;
                    if (count_r == 8'h00) begin
                        state_nxt = SER_CMD;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r <= SER_CMD;
            addr_r <= 5'h00;
            count_r <= 8'h00;
            is_write_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            count_r <= count_nxt;
            is_write_r <= is_write_nxt;
        end
    end

    // output line: data bits during a read-out, otherwise low while a result waits
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_sh_r <= 24'h000000;
            tx_active_r <= 1'b0;
            line_r <= 1'b1;
        end else begin
            if (tx_load) begin
                tx_sh_r <= tx_load_val;
                tx_active_r <= 1'b1;
            end else if (sclk_rise && tx_active_r) begin
                tx_sh_r <= {tx_sh_r[22:0], 1'b0};
                line_r <= tx_sh_r[23];
            end
            if (cs_s || (byte_done && state_nxt == SER_CMD && !tx_load)) begin
                tx_active_r <= 1'b0;
            end
            if (!tx_active_r && !tx_load) begin
                line_r <= !fifo_valid;
            end
        end
    end

    assign combined_out_ready_line = line_r;
    assign combined_out_ready_oe = !cs_s;

    // register writes
    assign chan_change = wr_en && (addr_r == `AMC_REG_CHAN) && (rx_byte != chan_r);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            chan_r <= `AMC_CHAN_RST;
            gain_r <= `AMC_GAIN_RST;
            rate_r <= `AMC_RATE_RST;
            sys_r <= `AMC_SYS_RST;
        end else if (wr_en) begin
            unique case (addr_r)
                `AMC_REG_CHAN: chan_r <= rx_byte;
                `AMC_REG_GAIN: gain_r <= rx_byte;
                `AMC_REG_RATE: rate_r <= rx_byte;
                `AMC_REG_SYS: sys_r <= rx_byte;
                default: ;
            endcase
        end
    end

    // break-before-make: hold at mid-supply, then connect the new pair
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bbm_cnt_r <= 6'h00;
            applied_chan_r <= `AMC_CHAN_RST;
        end else if (chan_change) begin
            bbm_cnt_r <= BBM_CYCLES;
        end else if (bbm_cnt_r != 6'h00) begin
            bbm_cnt_r <= bbm_cnt_r - 6'h01;
            if (bbm_cnt_r == 6'h01) begin
                applied_chan_r <= chan_r;
            end
        end
    end

    // any four-bit code, the common input included, passes through unchanged
    assign positive_input_select = applied_chan_r[`AMC_CHAN_POS_HI:`AMC_CHAN_POS_LO];
    assign negative_input_select = applied_chan_r[`AMC_CHAN_NEG_HI:`AMC_CHAN_NEG_LO];
    assign inputs_connected = (bbm_cnt_r == 6'h00);
    assign monitor_select = sys_r[`AMC_SYS_MON_HI:`AMC_SYS_MON_LO];
    assign inputs_mid_short = (bbm_cnt_r != 6'h00) || (monitor_select == `AMC_MON_SHORT);
    assign burnout_enable = sys_r[`AMC_SYS_BURN_BIT];

    // amplifier enable, gain and digital scaling
    assign gain_code = gain_r[`AMC_GAIN_HI:`AMC_GAIN_LO];
    assign pga_on = (gain_r[`AMC_GAIN_EN_HI:`AMC_GAIN_EN_LO] == `AMC_AMPLIFIER_POWER_ENABLE_ON);
    assign amplifier_power_enable = pga_on;

    always_comb begin
        pga_analog_gain = 3'h0;
        digital_gain_shift = 2'h0;
        if (pga_on) begin
            if (gain_code > `AMC_GAIN_CODE_32) begin
                pga_analog_gain = `AMC_GAIN_CODE_32;
                digital_gain_shift = 2'(gain_code - `AMC_GAIN_CODE_32);
            end else begin
                pga_analog_gain = gain_code;
            end
        end
    end

    // filter, rate, mode and clock source
    assign filter_low_latency = rate_r[`AMC_RATE_FILT_BIT];
    assign data_rate_code = (rate_r[`AMC_RATE_DR_HI:`AMC_RATE_DR_LO] > `AMC_DR_CODE_MAX) ?
        `AMC_DR_CODE_MAX : rate_r[`AMC_RATE_DR_HI:`AMC_RATE_DR_LO];
    assign single_shot_mode = rate_r[`AMC_RATE_MODE_BIT];
    assign clk_source_external = rate_r[`AMC_RATE_CLK_BIT];
    assign gpio_on_analog_inputs = (INPUT_COUNT == 12);

    // conversion run control
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            conv_run_r <= 1'b0;
        end else if (start_edge || start_cmd) begin
            conv_run_r <= 1'b1;
        end else if (stop_cmd) begin
            conv_run_r <= 1'b0;
        end else if (single_shot_mode && conv_result_valid && conv_result_ready) begin
            conv_run_r <= 1'b0;
        end
    end

    assign conv_run = conv_run_r;

    // last result repeats when the buffer is empty
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            last_r <= 16'h0000;
        end else if (pop) begin
            last_r <= fifo_out;
        end
    end

    amc_fifo #(
        .WIDTH(16),
        .DEPTH(8)
    ) u_result_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_data(conv_result),
        .in_valid(conv_result_valid),
        .in_ready(conv_result_ready),
        .out_data(fifo_out),
        .out_valid(fifo_valid),
        .out_ready(pop)
    );

endmodule : amc_top

// ### rtl/amc_consts.svh
// register offsets, field positions, reset values, commands and timing counts of the converter control
`ifndef AMC_CONSTS_SVH
`define AMC_CONSTS_SVH

// register offsets
`define AMC_REG_STATUS 5'h01
`define AMC_REG_CHAN 5'h02
`define AMC_REG_GAIN 5'h03
`define AMC_REG_RATE 5'h04
`define AMC_REG_SYS 5'h09

// reset values
`define AMC_CHAN_RST 8'h01
`define AMC_GAIN_RST 8'h00
`define AMC_RATE_RST 8'h14
`define AMC_SYS_RST 8'h00

// field positions
`define AMC_CHAN_POS_HI 7
`define AMC_CHAN_POS_LO 4
`define AMC_CHAN_NEG_HI 3
`define AMC_CHAN_NEG_LO 0
`define AMC_GAIN_EN_HI 4
`define AMC_GAIN_EN_LO 3
`define AMC_GAIN_HI 2
`define AMC_GAIN_LO 0
`define AMC_RATE_CLK_BIT 6
`define AMC_RATE_MODE_BIT 5
`define AMC_RATE_FILT_BIT 4
`define AMC_RATE_DR_HI 3
`define AMC_RATE_DR_LO 0
`define AMC_SYS_MON_HI 7
`define AMC_SYS_MON_LO 5
`define AMC_SYS_BURN_BIT 4
`define AMC_SYS_CRC_BIT 1

// field encodings
`define AMC_AMPLIFIER_POWER_ENABLE_ON 2'h1
`define AMC_GAIN_CODE_32 3'h5
`define AMC_DR_CODE_MAX 4'hD
`define AMC_MON_SHORT 3'h1

// serial commands
`define AMC_CMD_START 8'h08
`define AMC_CMD_STOP 8'h0A
`define AMC_CMD_RDATA 8'h12
`define AMC_CMD_RREG 3'h1
`define AMC_CMD_WREG 3'h2

// result check code
`define AMC_CRC_POLY 8'h07
`define AMC_CRC_INIT 8'hFF

// timing: mid-supply hold is two modulator clock periods
`define AMC_SYS_HZ 100000000
`define AMC_MOD_CLK_HZ 4096000
`define AMC_BBM_TCLK_PERIODS 2
`define AMC_BBM_CYC ((`AMC_BBM_TCLK_PERIODS * `AMC_SYS_HZ + `AMC_MOD_CLK_HZ - 1) / `AMC_MOD_CLK_HZ)

`endif

// ### rtl/amc_pkg.sv
// types shared by the converter control files
package amc_pkg;

    typedef enum logic [2:0] {
        SER_CMD,
        SER_COUNT,
        SER_WRITE,
        SER_READ,
        SER_DATA
    } amc_ser_state_type;

    typedef logic [15:0] amc_result_type;

endpackage : amc_pkg

// ### rtl/amc_fifo.sv
// result fifo with parameter width and depth, valid and ready on both sides
`timescale 1ns/1ps
module amc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = DEPTH[AW:0];

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign in_ready = (count_r != FULL_COUNT);
    assign out_valid = (count_r != '0);
    assign out_data = mem_r[rd_ptr_r];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // storage, depth is a power of two so pointers wrap naturally
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule : amc_fifo

// ### tb/amc_top_checker.sv
// port assertions for the converter control
`timescale 1ns/1ps
module amc_top_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic start_sync,
    input wire logic combined_out_ready_line,
    input wire logic conv_result_ready,
    input wire logic conv_run,
    input wire logic [3:0] positive_input_select,
    input wire logic [3:0] negative_input_select,
    input wire logic inputs_connected,
    input wire logic inputs_mid_short,
    input wire logic [2:0] monitor_select,
    input wire logic amplifier_power_enable,
    input wire logic [2:0] pga_analog_gain,
    input wire logic [1:0] digital_gain_shift,
    input wire logic [3:0] data_rate_code
);
    default clocking dcb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    logic [7:0] low_cnt_r;
    // length of the current disconnect interval
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            low_cnt_r <= 8'h00;
        end else if (!inputs_connected) begin
            low_cnt_r <= low_cnt_r + 8'h01;
        end else begin
            low_cnt_r <= 8'h00;
        end
    end
    a_bbm_hold_len: assert property ($rose(inputs_connected) |-> low_cnt_r == 8'h31)
        else $error("mid-supply hold length wrong");
    a_bbm_mid_short: assert property (!inputs_connected |-> inputs_mid_short)
        else $error("inputs detached but not at mid-supply");
    a_sel_after_hold: assert property (($changed(positive_input_select) || $changed(negative_input_select))
        |-> $rose(inputs_connected))
        else $error("selects changed without a hold");
    a_monitor_short: assert property (monitor_select == 3'h1 |-> inputs_mid_short)
        else $error("short monitor not applied");
    a_bypass_gain: assert property (!amplifier_power_enable |-> pga_analog_gain == 3'h0 &&
        digital_gain_shift == 2'h0)
        else $error("gain applied while bypassed");
    a_gain_cap: assert property (pga_analog_gain <= 3'h5 &&
        (digital_gain_shift == 2'h0 || pga_analog_gain == 3'h5))
        else $error("analog gain above 32 or scaling without 32");
    a_rate_range: assert property (data_rate_code <= 4'hD)
        else $error("rate code out of range");
    a_start_pin: assert property ($rose(start_sync) |-> ##[1:6] conv_run)
        else $error("start pin did not start conversions");
    a_ready_idle: assert property (cs_n [*6] ##0 !conv_result_ready |-> !combined_out_ready_line)
        else $error("waiting result not shown on output line");
    c_hold_done: cover property ($rose(inputs_connected));
    c_fifo_full: cover property (!conv_result_ready);
    c_run_start: cover property ($rose(conv_run));
    c_gain_128: cover property (digital_gain_shift == 2'h2);
endmodule : amc_top_checker

bind amc_top amc_top_checker u_checker (
    .clk_sys(clk_sys),
    .rst(rst),
    .cs_n(cs_n),
    .start_sync(start_sync),
    .combined_out_ready_line(combined_out_ready_line),
    .conv_result_ready(conv_result_ready),
    .conv_run(conv_run),
    .positive_input_select(positive_input_select),
    .negative_input_select(negative_input_select),
    .inputs_connected(inputs_connected),
    .inputs_mid_short(inputs_mid_short),
    .monitor_select(monitor_select),
    .amplifier_power_enable(amplifier_power_enable),
    .pga_analog_gain(pga_analog_gain),
    .digital_gain_shift(digital_gain_shift),
    .data_rate_code(data_rate_code)
);

// ### tb/amc_host_model.sv
// host side of the four-wire serial port
`timescale 1ns/1ps
module amc_host_model (
    input wire logic clk_sys,
    input wire logic out_line,
    output logic cs_n,
    output logic sclk,
    output logic din
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end
    // select or release the device; clock stays idle low outside frames
    task automatic sel(input logic on);
        @(negedge clk_sys);
        cs_n = !on;
        #160;
    endtask : sel
    // one byte, msb first, device samples on falling edge
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sclk = 1'b1;
            din = tx[i];
            #80;
            sclk = 1'b0;
            rx[i] = out_line;
            #80;
        end
    endtask : xbyte
endmodule : amc_host_model

// ### tb/testbench.sv
// self-checking bench for the converter control
`timescale 1ns/1ps
`include "amc_consts.svh"
module testbench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic start_sync;
    logic conv_result_valid;
    logic [15:0] conv_result;
    wire cs_n, sclk, din, line, oe;
    logic ready, run, conn, short_mid, burn, amp_en, low_lat, single, clk_ext, gpio_in;
    logic [3:0] pos, neg, rate;
    logic [2:0] mon, gain;
    logic [1:0] shift;
    int error_cnt = 0;
    int check_count = 0;
    int low_total = 0;
    always #5 clk_sys = !clk_sys;
    always @(posedge clk_sys) if (!conn) low_total <= low_total + 1;
    amc_top u_dut (
        .clk_sys(clk_sys),
        .rst(rst),
        .cs_n(cs_n),
        .sclk(sclk),
        .din(din),
        .start_sync(start_sync),
        .combined_out_ready_line(line),
        .combined_out_ready_oe(oe),
        .conv_result(conv_result),
        .conv_result_valid(conv_result_valid),
        .conv_result_ready(ready),
        .conv_run(run),
        .positive_input_select(pos),
        .negative_input_select(neg),
        .inputs_connected(conn),
        .inputs_mid_short(short_mid),
        .monitor_select(mon),
        .burnout_enable(burn),
        .amplifier_power_enable(amp_en),
        .pga_analog_gain(gain),
        .digital_gain_shift(shift),
        .filter_low_latency(low_lat),
        .data_rate_code(rate),
        .single_shot_mode(single),
        .clk_source_external(clk_ext),
        .gpio_on_analog_inputs(gpio_in)
    );
    amc_host_model u_host (
        .clk_sys(clk_sys),
        .out_line(line),
        .cs_n(cs_n),
        .sclk(sclk),
        .din(din)
    );
    task automatic summarize();
        if (error_cnt == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bound_fail();
        error_cnt++;
        $display("ERROR %0t: wait timed out", $time);
        summarize();
    endtask : bound_fail
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = `AMC_CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? `AMC_CRC_POLY : 8'h00);
        end
        return c;
    endfunction : crc8
    task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2, output logic [7:0] rx);
        logic [7:0] r;
        u_host.sel(1'b1);
        u_host.xbyte(b0, r);
        u_host.xbyte(b1, r);
        u_host.xbyte(b2, rx);
        u_host.sel(1'b0);
    endtask : frame
    task automatic wreg(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] r;
        frame({`AMC_CMD_WREG, a}, 8'h00, d, r);
    endtask : wreg
    task automatic rdata(input logic crc_on, output logic [23:0] d);
        logic [7:0] r;
        u_host.sel(1'b1);
        u_host.xbyte(`AMC_CMD_RDATA, r);
        chk(oe, 1'b1);
        u_host.xbyte(8'h00, d[23:16]);
        u_host.xbyte(8'h00, d[15:8]);
        d[7:0] = 8'h00;
        if (crc_on) begin
            u_host.xbyte(8'h00, d[7:0]);
        end
        u_host.sel(1'b0);
    endtask : rdata
    task automatic push(input logic [15:0] w, output bit took);
        @(negedge clk_sys);
        conv_result = w;
        took = ready;
        conv_result_valid = ready;
        @(negedge clk_sys);
        conv_result_valid = 1'b0;
    endtask : push
    task automatic t_reset();
        logic [7:0] d;
        chk({conn, pos, neg}, {1'b1, `AMC_CHAN_RST});
        chk({low_lat, rate, gpio_in}, 6'h29);
        frame({`AMC_CMD_RREG, `AMC_REG_RATE}, 8'h00, 8'h00, d);
        chk(d, `AMC_RATE_RST);
        frame({`AMC_CMD_RREG, 5'h05}, 8'h00, 8'h00, d);
        chk(d, 8'h00);
    endtask : t_reset
    task automatic t_chan();
        int n;
        n = low_total;
        wreg(`AMC_REG_CHAN, 8'hC3);
        chk({conn, short_mid}, 2'h1);
        for (int i = 0; i < 100 && conn !== 1'b1; i++) @(negedge clk_sys);
        if (conn !== 1'b1) bound_fail();
        chk(24'(low_total - n), 24'h000031);
        chk({pos, neg}, 8'hC3);
        n = low_total;
        wreg(`AMC_REG_CHAN, 8'hC3);
        chk(24'(low_total - n), 24'h000000);
    endtask : t_chan
    task automatic t_gain();
        for (int g = 0; g < 8; g++) begin
            wreg(`AMC_REG_GAIN, {3'h0, `AMC_AMPLIFIER_POWER_ENABLE_ON, 3'(g)});
            chk({amp_en, gain}, {1'b1, (g > 5) ? 3'h5 : 3'(g)});
            chk(shift, (g > 5) ? 2'(g - 5) : 2'h0);
        end
        wreg(`AMC_REG_GAIN, 8'h03);
        chk({amp_en, gain, shift}, 6'h00);
    endtask : t_gain
    task automatic t_rate();
        wreg(`AMC_REG_RATE, 8'h6D);
        chk({clk_ext, single, low_lat, rate}, 7'h6D);
        wreg(`AMC_REG_RATE, 8'h1F);
        chk({clk_ext, single, low_lat, rate}, 7'h1D);
    endtask : t_rate
    task automatic t_mon();
        for (int m = 1; m < 5; m++) begin
            wreg(`AMC_REG_SYS, {3'(m), 5'h10});
            chk({mon, burn, short_mid}, {3'(m), 1'b1, m == 1});
        end
    endtask : t_mon
    task automatic t_data();
        logic [23:0] d;
        logic [7:0] r;
        bit took;
        int n;
        frame(`AMC_CMD_START, 8'h00, 8'h00, r);
        chk(run, 1'b1);
        wreg(`AMC_REG_SYS, 8'h00);
        n = 0;
        for (int i = 0; i < 10; i++) begin
            push(16'hA500 + 16'(i), took);
            n += took;
        end
        chk(24'(n), 24'h000008);
        chk(line, 1'b0);
        for (int i = 0; i < 8; i++) begin
            rdata(1'b0, d);
            chk(d[23:8], 16'hA500 + 16'(i));
        end
        chk(line, 1'b1);
        wreg(`AMC_REG_SYS, 8'h02);
        push(16'h1234, took);
        rdata(1'b1, d);
        chk(d, {16'h1234, crc8(16'h1234)});
    endtask : t_data
    task automatic t_pins();
        logic [7:0] r;
        u_host.sel(1'b1);
        u_host.xbyte(`AMC_CMD_STOP, r);
        #160;
        chk(run, 1'b0);
        u_host.xbyte(`AMC_CMD_START, r);
        #160;
        chk(run, 1'b1);
        u_host.xbyte(`AMC_CMD_STOP, r);
        u_host.sel(1'b0);
        chk(run, 1'b0);
        start_sync = 1'b1;
        for (int i = 0; i < 20 && run !== 1'b1; i++) @(negedge clk_sys);
        if (run !== 1'b1) bound_fail();
        start_sync = 1'b0;
        chk(run, 1'b1);
    endtask : t_pins
    initial begin
        {start_sync, conv_result_valid, conv_result} = '0;
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        repeat (3) @(negedge clk_sys);
        t_reset();
        t_chan();
        t_gain();
        t_rate();
        t_mon();
        t_data();
        t_pins();
        summarize();
    end
endmodule : testbench
